//--- src/adl_delay_core.sv
/*
  digital model of a two-bank charge transfer analog delay line.
  each bank is a shift register advanced by its own transport phase 1
  edge; samples load on the sample clock edge; both banks merge at one
  detector, recharged by the reset clock. all clocks are pins sampled
  by mclk, which must run much faster than any pin clock.
*/
`timescale 1ns/10ps
`include "adl_defines.svh"
module adl_delay_core #(
  parameter int STAGES = `ADL_STAGES
) (
  input  wire logic                   mclk,
  input  wire logic                   rst_b,
  input  wire adl_pkg::adl_bank_clk_s clk_a,
  input  wire adl_pkg::adl_bank_clk_s clk_b,
  input  wire logic                   reset_clock,
  input  wire adl_pkg::adl_sample_t   analog_input_a,
  input  wire adl_pkg::adl_sample_t   analog_input_b,
  output adl_pkg::adl_sample_t        signal_output,
  output logic                        comp_output,
  output logic                        output_valid
);
  // sample clocks rest high on an unused bank, every other pin rests low
  localparam logic [`ADL_PINS-1:0] IDLE_LV = `ADL_IDLE_MASK;

  // det_a and det_b hold the packet that left the last stage, so a sample
  // spends exactly STAGES transport periods in its bank before delivery
  typedef struct packed {
    logic [STAGES-1:0][`ADL_DATA_W-1:0] bank_a;
    logic [STAGES-1:0][`ADL_DATA_W-1:0] bank_b;
    logic [`ADL_DATA_W-1:0]             det_a;
    logic [`ADL_DATA_W-1:0]             det_b;
    logic [`ADL_DATA_W-1:0]             out_r;
    logic                               comp_r;
    logic                               valid_r;
    logic                               pend_a;
    logic                               pend_b;
  } adl_core_s;

  adl_core_s            st_r;
  adl_core_s            st_nxt;
  logic [`ADL_PINS-1:0] pin_raw;
  logic [`ADL_PINS-1:0] pin_lv;
  logic [`ADL_PINS-1:0] pin_rise;
  logic                 sa_lv;
  logic                 sb_lv;
  logic                 s_ra;
  logic                 s_rb;
  logic                 p1a_rise;
  logic                 p1b_rise;
  logic                 p1a_lv;
  logic                 p1b_lv;
  logic                 p2a_lv;
  logic                 p2b_lv;
  logic                 rc_lv;
  logic                 rc_rise;

  // the detector sees charge, so the delivered level is the inverse
  function automatic logic [`ADL_DATA_W-1:0] detect(
    input logic [`ADL_DATA_W-1:0] packet
  );
    return ~packet;
  endfunction

  assign pin_raw[`ADL_PIN_SA]  = clk_a.sample_clock;
  assign pin_raw[`ADL_PIN_SB]  = clk_b.sample_clock;
  assign pin_raw[`ADL_PIN_P1A] = clk_a.phase1;
  assign pin_raw[`ADL_PIN_P1B] = clk_b.phase1;
  assign pin_raw[`ADL_PIN_P2A] = clk_a.phase2;
  assign pin_raw[`ADL_PIN_P2B] = clk_b.phase2;
  assign pin_raw[`ADL_PIN_RC]  = reset_clock;

  // every pin clock is asynchronous to mclk and gets the same latency,
  // so the order of pin edges survives into the mclk domain
  for (genvar i = 0; i < `ADL_PINS; i++) begin : g_sync
    adl_pin_sync #(
      .IDLE (IDLE_LV[i])
    ) u_sync (
      .mclk  (mclk),
      .rst_b (rst_b),
      .pin   (pin_raw[i]),
      .level (pin_lv[i]),
      .rise  (pin_rise[i])
    );
  end

  assign sa_lv    = pin_lv[`ADL_PIN_SA];
  assign sb_lv    = pin_lv[`ADL_PIN_SB];
  assign s_ra     = pin_rise[`ADL_PIN_SA];
  assign s_rb     = pin_rise[`ADL_PIN_SB];
  assign p1a_rise = pin_rise[`ADL_PIN_P1A];
  assign p1b_rise = pin_rise[`ADL_PIN_P1B];
  assign p1a_lv   = pin_lv[`ADL_PIN_P1A];
  assign p1b_lv   = pin_lv[`ADL_PIN_P1B];
  assign p2a_lv   = pin_lv[`ADL_PIN_P2A];
  assign p2b_lv   = pin_lv[`ADL_PIN_P2B];
  assign rc_lv    = pin_lv[`ADL_PIN_RC];
  assign rc_rise  = pin_rise[`ADL_PIN_RC];

  always_comb begin
    st_nxt        = st_r;
    st_nxt.comp_r = rc_lv;
    // a held-high sample clock never rises, so an idle bank loads nothing
    if (s_ra) begin
      st_nxt.bank_a[0] = analog_input_a;
    end
    if (s_rb) begin
      st_nxt.bank_b[0] = analog_input_b;
    end
    // each phase-1 rise moves one stage; banks are independent
    if (p1a_rise) begin
      st_nxt.det_a  = st_r.bank_a[STAGES-1];
      st_nxt.bank_a = {st_r.bank_a[STAGES-2:0], st_nxt.bank_a[0]};
      st_nxt.pend_a = 1'b1;
    end
    if (p1b_rise) begin
      st_nxt.det_b  = st_r.bank_b[STAGES-1];
      st_nxt.bank_b = {st_r.bank_b[STAGES-2:0], st_nxt.bank_b[0]};
      st_nxt.pend_b = 1'b1;
    end
    // detector reset clears then takes the next pending packet, a first;
    // a shift in the same cycle re-arms the flag, so no packet is lost
    if (rc_rise) begin
      if (st_r.pend_a) begin
        st_nxt.out_r   = detect(st_r.det_a);
        st_nxt.pend_a  = p1a_rise;
        st_nxt.valid_r = 1'b1;
      end else if (st_r.pend_b) begin
        st_nxt.out_r   = detect(st_r.det_b);
        st_nxt.pend_b  = p1b_rise;
        st_nxt.valid_r = 1'b1;
      end else begin
        st_nxt.valid_r = 1'b0;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign signal_output = st_r.out_r;
  assign comp_output   = st_r.comp_r;
  assign output_valid  = st_r.valid_r;

  a_comp_follows: assert property (
    @(posedge mclk) disable iff (!rst_b)
    rst_b && $past(rst_b) |-> comp_output == $past(rc_lv))
    else $error("compensation output does not follow reset clock");

  a_load_a: assert property (
    @(posedge mclk) disable iff (!rst_b)
    s_ra && !p1a_rise |=> st_r.bank_a[0] == $past(analog_input_a))
    else $error("bank a did not load sample");

  a_load_b: assert property (
    @(posedge mclk) disable iff (!rst_b)
    s_rb && !p1b_rise |=> st_r.bank_b[0] == $past(analog_input_b))
    else $error("bank b did not load sample");

  a_shift_a: assert property (
    @(posedge mclk) disable iff (!rst_b)
    p1a_rise |=> st_r.bank_a[1] == $past(st_r.bank_a[0]))
    else $error("bank a did not advance");

  a_shift_b: assert property (
    @(posedge mclk) disable iff (!rst_b)
    p1b_rise |=> st_r.bank_b[1] == $past(st_r.bank_b[0]))
    else $error("bank b did not advance");

  a_last_stage: assert property (
    @(posedge mclk) disable iff (!rst_b)
    p1a_rise |=> st_r.det_a == $past(st_r.bank_a[STAGES-1]))
    else $error("bank a last stage not passed to detector");

  a_out_inverts: assert property (
    @(posedge mclk) disable iff (!rst_b)
    rc_rise && st_r.pend_a |=> signal_output == ~$past(st_r.det_a))
    else $error("output is not the inverted packet of bank a");

  a_b_after_a: assert property (
    @(posedge mclk) disable iff (!rst_b)
    rc_rise && !st_r.pend_a && st_r.pend_b
      |=> signal_output == ~$past(st_r.det_b))
    else $error("bank b packet not delivered");

  a_valid_empty: assert property (
    @(posedge mclk) disable iff (!rst_b)
    rc_rise && !st_r.pend_a && !st_r.pend_b |=> !output_valid)
    else $error("valid raised with no packet");

  a_hold_no_reset: assert property (
    @(posedge mclk) disable iff (!rst_b)
    !rc_rise |=> $stable(signal_output))
    else $error("output changed without detector reset");

  a_idle_no_load: assert property (
    @(posedge mclk) disable iff (!rst_b)
    (sb_lv && !p1b_rise) [*2] |=> $stable(st_r.bank_b))
    else $error("idle bank b changed");

  a_idle_a: assert property (
    @(posedge mclk) disable iff (!rst_b)
    (sa_lv && !p1a_rise) [*2] |=> $stable(st_r.bank_a))
    else $error("idle bank a changed");

  a_nonoverlap_a: assert property (
    @(posedge mclk) disable iff (!rst_b)
    !(p1a_lv && p2a_lv))
    else $error("bank a phases overlap");

  a_nonoverlap_b: assert property (
    @(posedge mclk) disable iff (!rst_b)
    !(p1b_lv && p2b_lv))
    else $error("bank b phases overlap");
endmodule

//--- src/adl_defines.svh
/*
  shared constants for the dual bank analog delay clocking model.
  assumes inclusion by bare name from design files.
*/
`ifndef ADL_DEFINES_SVH
`define ADL_DEFINES_SVH
`define ADL_STAGES        130
`define ADL_SINGLE_DELAY  260
`define ADL_PAIR_DELAY_B  261
`define ADL_DATA_W        8
`define ADL_SAMP_W        8
`define ADL_PINS          7
`define ADL_PIN_SA        0
`define ADL_PIN_SB        1
`define ADL_PIN_P1A       2
`define ADL_PIN_P1B       3
`define ADL_PIN_P2A       4
`define ADL_PIN_P2B       5
`define ADL_PIN_RC        6
`define ADL_IDLE_MASK     7'h03
`endif

//--- src/adl_pkg.sv
/*
  types for the dual bank analog delay clocking model.
  assumes adl_defines.svh is on the include path.
*/
`include "adl_defines.svh"
package adl_pkg;
  typedef logic [`ADL_DATA_W-1:0] adl_sample_t;
  typedef struct packed {
    logic sample_clock;
    logic phase1;
    logic phase2;
  } adl_bank_clk_s;
  typedef struct packed {
    logic [2:0] s_r;
    logic       prev_r;
  } adl_sync_s;
endpackage

//--- src/adl_pin_sync.sv
/*
  three-stage pin synchroniser with agreement of stages two and three.
  assumes the pin is asynchronous to mclk and rests at IDLE between uses.
*/
`timescale 1ns/10ps
module adl_pin_sync #(
  parameter logic IDLE = 1'b0
) (
  input  wire logic mclk,
  input  wire logic rst_b,
  input  wire logic pin,
  output logic      level,
  output logic      rise
);
  adl_pkg::adl_sync_s st_r;
  adl_pkg::adl_sync_s st_nxt;

  always_comb begin
    st_nxt        = st_r;
    st_nxt.s_r    = {st_r.s_r[1:0], pin};
    if (st_r.s_r[1] == st_r.s_r[2]) begin
      st_nxt.prev_r = st_r.s_r[2];
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      // seeding with the idle level keeps a resting pin from faking an edge
      st_r <= '{s_r: {$bits(st_nxt.s_r){IDLE}}, prev_r: IDLE};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign level = st_r.prev_r;
  assign rise  = (st_r.s_r[1] == st_r.s_r[2]) && st_r.s_r[2] && !st_r.prev_r;
endmodule

//--- test/adl_timing_gen.sv
/*
  timing generator and input source for the delay core pins.
  assumes a 100 MHz mclk; one transport period is 16 mclk (160 ns).
*/
`timescale 1ns/10ps
module adl_timing_gen (
  input  wire logic                 mclk,
  input  wire logic [1:0]           mode,
  input  wire logic                 run,
  input  wire adl_pkg::adl_sample_t data,
  output logic [3:0]                cnt,
  output adl_pkg::adl_bank_clk_s    clk_a,
  output adl_pkg::adl_bank_clk_s    clk_b,
  output logic                      reset_clock,
  output adl_pkg::adl_sample_t      analog_input_a,
  output adl_pkg::adl_sample_t      analog_input_b
);
  logic ph1;
  logic ph2;
  logic ea;
  logic eb;
  initial cnt = 4'h0;
  // one transport period per 16 mclk, scaled from the typical rates
  always @(negedge mclk) cnt <= cnt + 4'h1;
  // gaps at 6,7 and 13 keep the phases apart
  assign ph1 = cnt >= 4'h8 && cnt <= 4'hc;
  assign ph2 = cnt >= 4'he || cnt <= 4'h5;
  assign ea = mode != 2'h1;
  assign eb = mode != 2'h0;
  // idle bank: phases and input low, sample clock high
  assign clk_a = '{!(run && ea) || cnt <= 4'h2, ph1 && ea, ph2 && ea};
  assign clk_b = '{!(run && eb) || (cnt >= 4'h4 && cnt <= 4'h6),
                   ph1 && eb, ph2 && eb};
  assign analog_input_a = ea ? data : 8'h00;
  assign analog_input_b = eb ? data : 8'h00;
  // one recharge per shift, a second one in mode 2 when both banks carry packets
  assign reset_clock = cnt >= 4'hc ||
                       (mode == 2'h2 && cnt >= 4'h4 && cnt <= 4'h7);
endmodule

//--- test/dual_bank_analog_delay_clocking_bench.sv
/*
  self-checking bench: bank a alone, bank b alone, then interleaved.
  assumes the core is built with STAGES shortened to 4.
*/
`timescale 1ns/10ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin mismatches++; \
  $display("FAIL %0t got %h exp %h", $time, g, e); end end
module dual_bank_analog_delay_clocking_bench;
  logic                   mclk = 1'b0;
  logic                   rst_b = 1'b0;
  logic [1:0]             mode = 2'h0;
  logic                   run = 1'b0;
  adl_pkg::adl_sample_t   data = 8'h00;
  adl_pkg::adl_sample_t   v;
  adl_pkg::adl_sample_t   e;
  logic [3:0]             cnt;
  adl_pkg::adl_bank_clk_s clk_a;
  adl_pkg::adl_bank_clk_s clk_b;
  logic                   reset_clock;
  adl_pkg::adl_sample_t   analog_input_a;
  adl_pkg::adl_sample_t   analog_input_b;
  adl_pkg::adl_sample_t   signal_output;
  logic                   comp_output;
  logic                   output_valid;
  int                     mismatches = 0;
  int                     checked = 0;
  int                     n = 0;
  int                     dchk = 0;
  adl_pkg::adl_sample_t   hist[$];
  localparam int          STG = 4;
  always #5 mclk = ~mclk;
  adl_timing_gen i_adl_timing_gen (.*);
  adl_delay_core #(.STAGES(STG)) i_adl_delay_core (.*);
  // a sample of period k leaves the detector in period k + STG
  function automatic adl_pkg::adl_sample_t exp_out(int idx);
    return ~hist[idx];
  endfunction
  task automatic results();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // new value each period, corners first; interleave samples it twice
  always @(negedge mclk) if (cnt == 4'hf && run) begin
    v = n == 0 ? 8'h00 : n == 1 ? 8'hff : adl_pkg::adl_sample_t'($urandom);
    data <= v;
    hist.push_back(v);
    n++;
  end
  always @(posedge mclk) if (rst_b && run) begin
    if ((cnt == 4'h3 || (cnt == 4'hb && mode == 2'h2)) &&
        hist.size() > STG) begin
      e = exp_out(hist.size() - 1 - STG);
      `CHK(signal_output, e)
      `CHK(output_valid, 1'b1)
      dchk++;
    end
    if (cnt == 4'h2) `CHK(comp_output, 1'b1)
    if (cnt == 4'hb && mode != 2'h2) `CHK(comp_output, 1'b0)
  end
  initial begin
    void'($urandom(32'hc1af71f9));
    for (int m = 0; m < 3; m++) begin
      @(negedge mclk iff cnt == 4'h2);
      rst_b = 1'b0;
      run = 1'b0;
      mode = m[1:0];
      hist.delete();
      n = 0;
      dchk = 0;
      repeat (6) @(negedge mclk);
      rst_b = 1'b1;
      run = 1'b1;
      repeat (320) @(negedge mclk);
      // every mode must have delivered delayed packets
      `CHK(dchk > 0, 1'b1)
    end
    results();
  end
  initial begin
    repeat (3000) @(posedge mclk);
    mismatches++;
    results();
  end
endmodule
